// ---- design/tpx_regs.vh ----
// Register offsets, field positions and constants of the PWM output stage
`ifndef TPX_REGS_VH
`define TPX_REGS_VH

// Register word addresses (word index, not scaled to bytes)
`define TPX_ADDR_MODE     4'h0
`define TPX_ADDR_COUNTER  4'h1
`define TPX_ADDR_RELOAD   4'h2
`define TPX_ADDR_DUTY     4'h3
`define TPX_ADDR_PINSEL   4'h4
`define TPX_ADDR_EXTSEL   4'h5
`define TPX_ADDR_GPIO     4'h6
`define TPX_ADDR_STATUS   4'h7
`define TPX_ADDR_MASK     4'h8

// Mode register fields
`define TPX_MODE_TEN      0
`define TPX_MODE_OUTEN    1
`define TPX_MODE_SINGLE   2

// Pin select and extension fields
`define TPX_PINSEL_A      4
`define TPX_PINSEL_B      5
`define TPX_EXT_LO        4
`define TPX_EXT_HI        5

// GPIO register fields: per pin output level and direction
`define TPX_GPIO_LVL_A    0
`define TPX_GPIO_LVL_B    1
`define TPX_GPIO_OE_A     2
`define TPX_GPIO_OE_B     3

// Status fields
`define TPX_ST_OVF        0
`define TPX_ST_PULSE      1

// Counter and extension constants
`define TPX_CNT_MAX       8'hFF
`define TPX_CNT_STRETCH   8'hFE
`define TPX_EXT_NONE      2'h0
`define TPX_EXT_P1        2'h1
`define TPX_EXT_P13       2'h2
`define TPX_EXT_P123      2'h3
`define TPX_PH1           2'h1
`define TPX_PH2           2'h2
`define TPX_PH3           2'h3
`define TPX_SYNC_ONE      2'h1

`endif

// ---- design/tpx_pin_mux.v ----
// Pin multiplexer: PWM waveform or GPIO idle state per pin
`timescale 1ns/1ps
`default_nettype none
module tpx_pin_mux #(
    parameter N = 2
) (
    // Selection
    input  wire [N-1:0] sel,
    input  wire         pwm_level,
    // GPIO idle configuration
    input  wire [N-1:0] gpio_level,
    input  wire [N-1:0] gpio_drive,
    // Pins
    output wire [N-1:0] pin_o,
    output wire [N-1:0] pin_oe
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_pin
            // Same waveform on every selected pin, no delay added
            assign pin_o[i]  = sel[i] ? pwm_level : gpio_level[i]; // R3
            // Idle follows GPIO: drive high, drive low, or released
            assign pin_oe[i] = sel[i] | gpio_drive[i]; // R2
        end
    endgenerate
endmodule // tpx_pin_mux
`default_nettype wire

// ---- design/tpx_pwm.v ----
// Timer PWM output stage with one-pulse and four-phase extension
// Behaviour
// R1: Pin select bits route PWM, else GPIO
// R2: Disabled pin idles per its GPIO setting
// R3: Pins carry identical PWM, no phase shift
// R4: Single-pulse select chooses one pulse mode
// R5: Pin switches only after output sync
// R6: Finished pulse clears output enable itself
// R7: Single-pulse overflow raises timer overflow request
// R8: Software re-arms output enable per pulse
// R9: Extension ignored in single-pulse mode
// R10: Extension code zero gives plain PWM
// R11: Extended cycle is four sub-cycles
// R12: Compensated phase stretches high one count
// R13: Extension code change waits for cycle end
// R14: Software loads counter equal to reload
// R15: Software keeps duty above reload
// R16: High after reload, low at duty match
// R17: Codes 01,10,11 pick compensated phases
// R18: Timer re-enable resets phase counter
// R19: Software sets output enable before timer
`timescale 1ns/1ps
`default_nettype none
`include "tpx_regs.vh"
module tpx_pwm #(
    parameter W = 8,
    parameter N = 2
) (
    // Clock, reset and enable
    input  wire          clock,
    input  wire          sys_rst,
    input  wire          clk_en,
    // Avalon-MM slave
    input  wire [3:0]    avs_address,
    input  wire          avs_read,
    input  wire          avs_write,
    input  wire [31:0]   avs_writedata,
    output reg  [31:0]   avs_readdata,
    output wire          avs_waitrequest,
    // Pins shared with GPIO
    output wire [N-1:0]  pwm_pin_o,
    output wire [N-1:0]  pwm_pin_oe,
    // Interrupt and waveform
    output wire          irq,
    output reg           pwm_level_reg
);
    // Registers
    reg [2:0]   mode_reg;
    reg [W-1:0] counter_reg;
    reg [W-1:0] reload_reg;
    reg [W-1:0] duty_reg;
    reg [N-1:0] pin_select_reg;
    reg [1:0]   ext_code_reg;
    reg [1:0]   ext_pending_reg;
    reg [1:0]   gpio_level_reg;
    reg [1:0]   gpio_drive_reg;
    reg [1:0]   status_reg;
    reg [1:0]   mask_reg;
    reg [1:0]   phase_reg;
    reg         stretch_reg;
    reg         synced_reg;
    reg         ten_d_reg;
    reg         ack_reg;

    wire ten    = mode_reg[`TPX_MODE_TEN];
    wire outen  = mode_reg[`TPX_MODE_OUTEN];
    wire single = mode_reg[`TPX_MODE_SINGLE];
    // Write lands at the edge where waitrequest is low; a read is
    // captured one edge earlier so its data stands at that edge
    wire wr     = avs_write & ack_reg;
    wire rd     = avs_read & ~ack_reg;
    wire tick   = clk_en & ten;
    // Next counter value, kept at counter width
    wire [W-1:0] cnt_step = counter_reg + {{(W-2){1'b0}}, `TPX_SYNC_ONE};
    wire ext_on = ~single & (ext_code_reg != `TPX_EXT_NONE); // R9 R10
    // Compensated phase selection by extension code
    reg  comp_phase;
    always @* begin
        case (ext_code_reg) // R17
            `TPX_EXT_P1:   comp_phase = (phase_reg == `TPX_PH1);
            `TPX_EXT_P13:  comp_phase = (phase_reg == `TPX_PH1) |
                                        (phase_reg == `TPX_PH3);
            `TPX_EXT_P123: comp_phase = (phase_reg != 2'h0);
            default:       comp_phase = 1'b0;
        endcase
    end
    wire do_stretch = tick & ext_on & comp_phase & ~stretch_reg &
                      (counter_reg == `TPX_CNT_MAX);
    // Overflow is held back one tick while a stretch is inserted
    wire ovf        = tick & (counter_reg == `TPX_CNT_MAX) & ~do_stretch;
    // Without extension every overflow closes the cycle, else phase 3
    wire cycle_end  = ovf & (~ext_on | (phase_reg == `TPX_PH3));
    wire pulse_done = ovf & single & outen & synced_reg;
    // Counter steps onto the duty value: high time is duty minus reload
    wire duty_hit   = tick & (cnt_step == duty_reg);

    // One wait state per access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    always @(posedge clock) begin
        if (sys_rst)
            ack_reg <= 1'b0;
        else if (clk_en)
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    // Register writes, hardware updates
    always @(posedge clock) begin
        if (sys_rst) begin
            mode_reg        <= 3'h0;
            reload_reg      <= {W{1'b0}};
            duty_reg        <= {W{1'b0}};
            pin_select_reg  <= {N{1'b0}};
            ext_code_reg    <= 2'h0;
            ext_pending_reg <= 2'h0;
            gpio_level_reg  <= 2'h0;
            gpio_drive_reg  <= 2'h0;
            mask_reg        <= 2'h0;
            status_reg      <= 2'h0;
        end else if (clk_en) begin
            if (wr) begin
                case (avs_address)
                    `TPX_ADDR_MODE:   mode_reg <= avs_writedata[2:0];
                    `TPX_ADDR_RELOAD: reload_reg <= avs_writedata[W-1:0];
                    `TPX_ADDR_DUTY:   duty_reg <= avs_writedata[W-1:0];
                    `TPX_ADDR_PINSEL: pin_select_reg <= // R1
                        avs_writedata[`TPX_PINSEL_B:`TPX_PINSEL_A];
                    `TPX_ADDR_EXTSEL: ext_pending_reg <= // R13
                        avs_writedata[`TPX_EXT_HI:`TPX_EXT_LO];
                    `TPX_ADDR_GPIO: begin
                        gpio_level_reg <=
                            avs_writedata[`TPX_GPIO_LVL_B:`TPX_GPIO_LVL_A];
                        gpio_drive_reg <=
                            avs_writedata[`TPX_GPIO_OE_B:`TPX_GPIO_OE_A];
                    end
                    `TPX_ADDR_MASK:   mask_reg <= avs_writedata[1:0];
                    default: ;
                endcase
            end
            // Pending code takes effect at cycle end or while idle
            if (cycle_end | ~ten | ~outen)
                ext_code_reg <= wr && avs_address == `TPX_ADDR_EXTSEL ?
                    avs_writedata[`TPX_EXT_HI:`TPX_EXT_LO] :
                    ext_pending_reg; // R13
            // Pulse done clears output enable, clear wins over a same-cycle mode write
            if (pulse_done)
                mode_reg[`TPX_MODE_OUTEN] <= 1'b0; // R6
            // Sticky status: write one clears, new event wins
            status_reg <= (status_reg &
                ~((wr && avs_address == `TPX_ADDR_STATUS) ?
                  avs_writedata[1:0] : 2'h0)) |
                {pulse_done, ovf}; // R7
        end
    end

    // Counter, phase sequencer, sync and waveform
    always @(posedge clock) begin
        if (sys_rst) begin
            counter_reg   <= {W{1'b0}};
            phase_reg     <= 2'h0;
            stretch_reg   <= 1'b0;
            synced_reg    <= 1'b0;
            ten_d_reg     <= 1'b0;
            pwm_level_reg <= 1'b0;
        end else if (clk_en) begin
            ten_d_reg <= ten;
            if (wr && avs_address == `TPX_ADDR_COUNTER)
                counter_reg <= avs_writedata[W-1:0];
            else if (ten & ~ten_d_reg) begin
                counter_reg <= reload_reg; // R16
                phase_reg   <= 2'h0; // R18
                stretch_reg <= 1'b0;
            end else if (do_stretch)
                stretch_reg <= 1'b1; // R12
            else if (ovf) begin
                counter_reg <= reload_reg; // R16
                stretch_reg <= 1'b0;
                if (ext_on)
                    phase_reg <= phase_reg + `TPX_SYNC_ONE; // R11
                else
                    phase_reg <= 2'h0;
            end else if (tick) begin
                counter_reg <= cnt_step;
                stretch_reg <= 1'b0;
            end
            // Output sync: pin switches after first aligned tick
            if (~ten | ~outen)
                synced_reg <= 1'b0;
            else if (tick)
                synced_reg <= 1'b1; // R5
            // High after reload, low at duty match, stretched in phase
            if (~ten | ~outen)
                pwm_level_reg <= 1'b0;
            else if (ovf | (ten & ~ten_d_reg))
                pwm_level_reg <= ~pulse_done; // R16 R4
            else if (duty_hit & ~do_stretch)
                pwm_level_reg <= 1'b0; // R15
            else if (do_stretch)
                pwm_level_reg <= 1'b1; // R12
        end
    end

    // Read mux; unmapped addresses read zero
    always @(posedge clock) begin
        if (sys_rst)
            avs_readdata <= 32'h0000_0000;
        else if (clk_en && rd) begin
            case (avs_address)
                `TPX_ADDR_MODE:    avs_readdata <= {29'h0, mode_reg};
                `TPX_ADDR_COUNTER: avs_readdata <= {{(32-W){1'b0}}, counter_reg};
                `TPX_ADDR_RELOAD:  avs_readdata <= {{(32-W){1'b0}}, reload_reg};
                `TPX_ADDR_DUTY:    avs_readdata <= {{(32-W){1'b0}}, duty_reg};
                `TPX_ADDR_PINSEL:  avs_readdata <= {26'h0, pin_select_reg, 4'h0};
                `TPX_ADDR_EXTSEL:  avs_readdata <= {26'h0, ext_pending_reg, 4'h0};
                `TPX_ADDR_GPIO:    avs_readdata <=
                                   {28'h0, gpio_drive_reg, gpio_level_reg};
                `TPX_ADDR_STATUS:  avs_readdata <= {30'h0, status_reg};
                `TPX_ADDR_MASK:    avs_readdata <= {30'h0, mask_reg};
                default:           avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    assign irq = |(status_reg & mask_reg);

    // Pin routing: active only while enabled and synchronised
    wire [N-1:0] route = pin_select_reg & {N{ten & outen & synced_reg}}; // R1 R5
    tpx_pin_mux #(.N(N)) u_mux (
        .sel        (route),
        .pwm_level  (pwm_level_reg),
        .gpio_level (gpio_level_reg),
        .gpio_drive (gpio_drive_reg),
        .pin_o      (pwm_pin_o),
        .pin_oe     (pwm_pin_oe)
    );
endmodule // tpx_pwm
`default_nettype wire

// ---- testbench/tpx_pwm_sva.sv ----
// Port checker for the PWM output stage
`timescale 1ns/1ps
`default_nettype none
`include "tpx_regs.vh"
module tpx_pwm_sva (
    // Clock and control
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    // Register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Pins and waveform
    input wire logic [1:0]  pwm_pin_o,
    input wire logic [1:0]  pwm_pin_oe,
    input wire logic        irq,
    input wire logic        pwm_level_reg
);
    logic [1:0] sel_reg, drv_reg, lvl_reg, msk_reg;
    wire logic  wr_ok = avs_write && !avs_waitrequest && clk_en;
    // Shadow of routing, idle and mask fields as software wrote them
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sel_reg <= 2'h0;
            drv_reg <= 2'h0;
            lvl_reg <= 2'h0;
            msk_reg <= 2'h0;
        end else if (wr_ok) begin
            if (avs_address == `TPX_ADDR_PINSEL)
                sel_reg <= avs_writedata[5:4];
            if (avs_address == `TPX_ADDR_GPIO) begin
                drv_reg <= avs_writedata[3:2];
                lvl_reg <= avs_writedata[1:0];
            end
            if (avs_address == `TPX_ADDR_MASK)
                msk_reg <= avs_writedata[1:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write)
        |-> avs_waitrequest) else $error("no wait in first cycle");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && clk_en
        && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest
        && avs_address > 4'h8 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !irq
        && pwm_pin_oe == 2'h0) else $error("pins or irq active after reset");
    AST_IDLE_DRIVE: assert property ((pwm_pin_oe & ~sel_reg)
        == (drv_reg & ~sel_reg)) else $error("idle drive wrong");
    AST_IDLE_LEVEL: assert property ((pwm_pin_o & drv_reg & ~sel_reg)
        == (lvl_reg & drv_reg & ~sel_reg)) else $error("idle level wrong");
    AST_PIN_PWM: assert property (sel_reg[0] && drv_reg[0]
        && pwm_pin_o[0] != lvl_reg[0] |-> pwm_pin_oe[0]
        && pwm_pin_o[0] == pwm_level_reg) else $error("pin A not waveform");
    AST_PIN_SAME: assert property (sel_reg == 2'h3 && drv_reg[0]
        && pwm_pin_o[0] != lvl_reg[0] |-> pwm_pin_o[1] == pwm_pin_o[0]
        && pwm_pin_oe == 2'h3) else $error("pins differ");
    AST_IRQ_MASKED: assert property (msk_reg == 2'h0 |-> !irq)
        else $error("irq with all masked");
endmodule // tpx_pwm_sva
`default_nettype wire

// ---- testbench/tpx_pwm_test.sv ----
// Self-checking bench for the PWM output stage
`timescale 1ns/1ps
`default_nettype none
`include "tpx_regs.vh"
module tpx_pwm_test;
    logic        clock, sys_rst, clk_en, avs_read, avs_write, v;
    logic        avs_waitrequest, irq, pwm_level_reg;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0]  pwm_pin_o, pwm_pin_oe;
    int          fail_count, checks_done, hc, tc, nr;
    tpx_pwm u_tpx_pwm (.clock, .sys_rst, .clk_en, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .pwm_pin_o, .pwm_pin_oe, .irq, .pwm_level_reg);
    // Clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Verdict and end of run
    task automatic close_out;
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        // Waitrequest is taken at each rising edge, read data at the edge where it is low
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk("bus answer", 32'h1, {31'h0, n < 40});
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [3:0] a,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Settled pin state
    task automatic pins(input logic [1:0] o, oe);
        @(negedge clock);
        chk("pin level", {30'h0, o}, {30'h0, pwm_pin_o});
        chk("pin drive", {30'h0, oe}, {30'h0, pwm_pin_oe});
    endtask
    // Rises, high and total cycles of pin A over four periods
    task automatic measure(input int lim);
        int t;
        logic p;
        hc = 0;
        tc = 0;
        nr = 0;
        p = 1'b1;
        for (t = 0; t < lim && nr < 5; t++) begin
            @(negedge clock);
            if (pwm_pin_o[0] && !p)
                nr++;
            if (nr > 0 && nr < 5) begin
                hc += pwm_pin_o[0];
                tc++;
            end
            p = pwm_pin_o[0];
        end
    endtask
    // Reset values, unmapped place, GPIO idle
    task automatic t_idle;
        rdc("mode", `TPX_ADDR_MODE, 32'h0);
        rdc("status", `TPX_ADDR_STATUS, 32'h0);
        wr(4'hC, 32'hFF);
        rdc("unmapped", 4'hC, 32'h0);
        wr(`TPX_ADDR_GPIO, 32'h0E);
        pins(2'h2, 2'h3);
        wr(`TPX_ADDR_GPIO, 32'h0C);
        pins(2'h0, 2'h3);
    endtask
    // Continuous waveform, every extension code, freeze, stop
    task automatic t_cont;
        int c;
        wr(`TPX_ADDR_COUNTER, 32'hF0);
        wr(`TPX_ADDR_RELOAD, 32'hF0);
        wr(`TPX_ADDR_DUTY, 32'hF8);
        wr(`TPX_ADDR_PINSEL, 32'h30);
        wr(`TPX_ADDR_MODE, 32'h2);
        wr(`TPX_ADDR_MODE, 32'h3);
        measure(300);
        chk("period", 32'd64, tc);
        for (c = 0; c < 4; c++) begin
            wr(`TPX_ADDR_EXTSEL, c << 4);
            repeat (140) @(posedge clock);
            measure(300);
            chk("high count", 32 + c, hc);
        end
        @(posedge clock);
        clk_en <= 1'b0;
        @(negedge clock);
        v = pwm_level_reg;
        repeat (20) @(posedge clock);
        chk("frozen level", {31'h0, v}, {31'h0, pwm_level_reg});
        clk_en <= 1'b1;
        wr(`TPX_ADDR_MODE, 32'h0);
        pins(2'h0, 2'h3);
    endtask
    // One pulse per arming, flag, mask and clear
    task automatic t_pulse;
        int i;
        wr(`TPX_ADDR_MASK, 32'h1);
        for (i = 0; i < 2; i++) begin
            wr(`TPX_ADDR_COUNTER, 32'hF0);
            wr(`TPX_ADDR_MODE, 32'h6);
            wr(`TPX_ADDR_MODE, 32'h7);
            measure(150);
            chk("pulses", 32'h1, nr);
            chk("pulse high", 32'd8, hc);
            rdc("mode after", `TPX_ADDR_MODE, 32'h5);
            pins(2'h0, 2'h3);
            chk("irq", 32'h1, {31'h0, irq});
            wr(`TPX_ADDR_MODE, 32'h4);
            rdc("flags", `TPX_ADDR_STATUS, 32'h3);
            wr(`TPX_ADDR_MASK, 32'h0);
            @(negedge clock);
            chk("irq masked", 32'h0, {31'h0, irq});
            wr(`TPX_ADDR_MASK, 32'h1);
            wr(`TPX_ADDR_STATUS, 32'h3);
            @(negedge clock);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
    endtask
    // Main sequence
    initial begin
        {sys_rst, clk_en, avs_read, avs_write} = 4'b1100;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        t_idle();
        t_cont();
        t_pulse();
        close_out();
    end
    // Watchdog
    initial begin
        repeat (6000) @(posedge clock);
        fail_count++;
        close_out();
    end
endmodule // tpx_pwm_test
bind tpx_pwm tpx_pwm_sva u_tpx_pwm_sva (.clock, .sys_rst, .clk_en,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .pwm_pin_o, .pwm_pin_oe, .irq, .pwm_level_reg);
`default_nettype wire
